//--- logic/ppp_port.sv
// Purpose: peripheral-side ieee 1284 port: compat, nibble, byte, ecp
// Assumes: host pins synchronous to clock; dma/cpu side is valid/ready
// Notes: no software registers; controls are plain ports
`timescale 1ns/1ps
`default_nettype none
module ppp_port (
    input wire logic clock,
    input wire logic rst_n,
    input wire ppp_pkg::ppp_mode_t mode,
    input wire logic [15:0] gran_div,
    input wire logic dma_mode,
    input wire logic cmd_store_dis,
    input wire logic ecp_enter,
    input wire ppp_pkg::ppp_host_pins_t host,
    output ppp_pkg::ppp_dev_pins_t dev,
    output logic [6:0] fwd_addr,
    output logic fwd_dat_valid,
    input wire logic fwd_dat_ready,
    output logic [7:0] fwd_dat_data,
    output logic fwd_cmd_valid,
    input wire logic fwd_cmd_ready,
    output logic [7:0] fwd_cmd_data,
    input wire logic rev_valid,
    output logic rev_ready,
    input wire logic [7:0] rev_data,
    output logic fwd_dat_dma_req,
    output logic fwd_cmd_dma_req,
    output logic rev_dma_req,
    input wire logic cpu_access,
    output logic bus_error
);
    import ppp_pkg::*;

    // ****************************************
    // port clock divider
    // ****************************************
    logic [15:0] div_ff, nxt_div;
    logic tick;
    assign tick = (div_ff == 16'h0000);
    always_comb begin
        nxt_div = tick ? ((gran_div == 16'h0000) ? gran_reset : gran_div) : div_ff - 16'h0001;
    end

    // ****************************************
    // fifos
    // ****************************************
    logic dat_in_valid, dat_in_ready, cmd_in_valid, cmd_in_ready;
    logic rv_out_valid, rv_out_ready, dat_empty, cmd_empty, rv_empty;
    logic [7:0] wr_byte_ff, nxt_wr_byte, rv_byte;
    logic dat_sel_ff, nxt_dat_sel;
    ppp_fifo u_fwd_dat (.clock(clock), .rst_n(rst_n), .in_valid(dat_in_valid),
        .in_ready(dat_in_ready), .in_data(wr_byte_ff), .out_valid(fwd_dat_valid),
        .out_ready(fwd_dat_ready), .out_data(fwd_dat_data), .empty(dat_empty));
    ppp_fifo u_fwd_cmd (.clock(clock), .rst_n(rst_n), .in_valid(cmd_in_valid),
        .in_ready(cmd_in_ready), .in_data(wr_byte_ff), .out_valid(fwd_cmd_valid),
        .out_ready(fwd_cmd_ready), .out_data(fwd_cmd_data), .empty(cmd_empty));
    ppp_fifo u_rev (.clock(clock), .rst_n(rst_n), .in_valid(rev_valid),
        .in_ready(rev_ready), .in_data(rev_data), .out_valid(rv_out_valid),
        .out_ready(rv_out_ready), .out_data(rv_byte), .empty(rv_empty));

    // forward dma keeps asking while bytes remain, reverse dma while the fifo has room; cpu mode drops requests
    assign fwd_dat_dma_req = dma_mode && !dat_empty;
    assign fwd_cmd_dma_req = dma_mode && !cmd_empty;
    assign rev_dma_req = dma_mode && rev_ready;
    assign bus_error = dma_mode && cpu_access;
    // bytes ride lane [7:0]; word packing and endian setup sit on the bus side

    // ****************************************
    // link state machine
    // ****************************************
    typedef enum logic [3:0] {
        st_idle, st_hold, st_fwd_ack, st_write, st_fwd_rel,
        st_rev_lo, st_rev_hi, st_rev_wait, st_rev_rel
    } ppp_state_t;
    ppp_state_t st_ff, nxt_st;
    logic [7:0] hold_ff, nxt_hold;
    logic [6:0] run_ff, nxt_run, addr_ff, nxt_addr;
    logic rle_ff, nxt_rle, nib_ff, nxt_nib;
    logic [7:0] out_ff, nxt_out;
    logic ack_ff, nxt_ack, pclk_ff, nxt_pclk, ackrev_ff, nxt_ackrev;
    logic host_clk_q_ff, host_rise;
    logic tgt_ready, reversing;

    assign host_rise = host.host_clk && !host_clk_q_ff;
    assign tgt_ready = dat_sel_ff ? dat_in_ready : cmd_in_ready;
    assign dat_in_valid = (st_ff == st_write) && dat_sel_ff;
    assign cmd_in_valid = (st_ff == st_write) && !dat_sel_ff;
    assign reversing = !host.reverse_req_n && mode != ppp_mode_compat;
    assign rv_out_ready = tick && rv_out_valid && !nib_ff &&
        ((st_ff == st_idle && mode != ppp_mode_ecp && reversing) ||
         (st_ff == st_idle && mode == ppp_mode_ecp && ackrev_ff));

    always_comb begin
        nxt_st = st_ff;
        nxt_hold = hold_ff;
        nxt_run = run_ff;
        nxt_addr = addr_ff;
        nxt_rle = rle_ff;
        nxt_nib = nib_ff;
        nxt_out = out_ff;
        nxt_ack = ack_ff;
        nxt_pclk = pclk_ff;
        nxt_ackrev = ackrev_ff;
        nxt_wr_byte = wr_byte_ff;
        nxt_dat_sel = dat_sel_ff;
        nxt_ackrev = (mode == ppp_mode_ecp) && !host.reverse_req_n && st_ff == st_idle
            ? 1'b1 : (host.reverse_req_n ? 1'b0 : ackrev_ff);
        unique case (st_ff)
            st_idle: begin
                if (ecp_enter) begin
                    nxt_ack = 1'b1;
                    nxt_hold = 8'(periph_ack_hold_cyc);
                    nxt_st = st_hold;
                end else if (tick && !reversing && !host.host_clk) begin
                    nxt_wr_byte = host.data;
                    nxt_dat_sel = (mode != ppp_mode_ecp) || host.host_ack;
                    nxt_ack = 1'b1;
                    nxt_st = st_fwd_ack;
                end else if (rv_out_ready) begin
                    nxt_out = rv_byte;
                    if (mode == ppp_mode_nibble) begin
                        nxt_nib = 1'b1;
                        nxt_out = {4'h0, rv_byte[3:0]};
                    end
                    nxt_hold = rv_byte;
                    nxt_pclk = 1'b0;
                    nxt_st = st_rev_lo;
                end
            end
            st_hold: begin
                nxt_hold = hold_ff - 8'h01;
                if (hold_ff == 8'h00) begin
                    nxt_ack = 1'b0;
                    nxt_st = st_idle;
                end
            end
            st_fwd_ack: begin
                if (!host.host_clk) begin
                    nxt_wr_byte = host.data; // latch tracks data until the rise
                    nxt_dat_sel = (mode != ppp_mode_ecp) || host.host_ack;
                end else if (host_rise || host.host_clk) begin
                    // the byte after a count is payload even when bit 7 is clear
                    if (mode == ppp_mode_ecp && !dat_sel_ff && !rle_ff &&
                        !wr_byte_ff[cmd_flag_bit]) begin
                        nxt_rle = 1'b1;
                        nxt_run = wr_byte_ff[6:0];
                        nxt_st = st_fwd_rel;
                    end else if (mode == ppp_mode_ecp && !dat_sel_ff && !rle_ff) begin
                        nxt_addr = wr_byte_ff[6:0];
                        nxt_st = st_fwd_rel;
                    end else begin
                        nxt_st = st_write;
                    end
                    if (mode == ppp_mode_ecp && !dat_sel_ff && rle_ff && cmd_store_dis) begin
                        nxt_st = st_fwd_rel;
                        nxt_rle = 1'b0;
                    end
                end
            end
            st_write: begin
                // stay busy while the target fifo is full
                if (tgt_ready) begin
                    if (rle_ff && run_ff != 7'h00) begin
                        nxt_run = run_ff - 7'h01;
                    end else begin
                        nxt_rle = 1'b0;
                        nxt_st = st_fwd_rel;
                    end
                end
            end
            st_fwd_rel: begin
                nxt_ack = 1'b0;
                if (host.host_clk) begin
                    nxt_st = st_idle;
                end
            end
            st_rev_lo: begin
                nxt_pclk = 1'b0;
                if (tick) begin
                    nxt_pclk = 1'b1;
                    nxt_st = st_rev_wait;
                end
            end
            st_rev_wait: begin
                if (host.host_ack) begin
                    nxt_st = st_rev_rel;
                end
            end
            st_rev_rel: begin
                if (!host.host_ack) begin
                    if (nib_ff) begin
                        nxt_nib = 1'b0;
                        nxt_out = {4'h0, hold_ff[7:4]};
                        nxt_pclk = 1'b0;
                        nxt_st = st_rev_lo;
                    end else begin
                        nxt_st = st_idle;
                    end
                end
            end
            st_rev_hi: nxt_st = st_idle;
            default: nxt_st = st_idle;
        endcase
        if (mode == ppp_mode_compat) begin
            nxt_nib = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_ff <= gran_reset;
            st_ff <= st_idle;
            hold_ff <= byte_zero;
            run_ff <= 7'h00;
            addr_ff <= addr_reset;
            rle_ff <= 1'b0;
            nib_ff <= 1'b0;
            out_ff <= byte_zero;
            ack_ff <= 1'b0;
            pclk_ff <= 1'b1;
            ackrev_ff <= 1'b0;
            wr_byte_ff <= byte_zero;
            dat_sel_ff <= 1'b1;
            host_clk_q_ff <= 1'b1;
        end else begin
            div_ff <= nxt_div;
            st_ff <= nxt_st;
            hold_ff <= nxt_hold;
            run_ff <= nxt_run;
            addr_ff <= nxt_addr;
            rle_ff <= nxt_rle;
            nib_ff <= nxt_nib;
            out_ff <= nxt_out;
            ack_ff <= nxt_ack;
            pclk_ff <= nxt_pclk;
            ackrev_ff <= nxt_ackrev;
            wr_byte_ff <= nxt_wr_byte;
            dat_sel_ff <= nxt_dat_sel;
            host_clk_q_ff <= host.host_clk;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    always_comb begin
        dev.data = out_ff;
        dev.data_oe_n = !(reversing && mode != ppp_mode_nibble);
        dev.periph_ack = ack_ff;
        dev.periph_clk = pclk_ff;
        dev.ack_reverse_n = !ackrev_ff;
        dev.periph_req_n = rv_empty;
        // in nibble mode fault_n and perror carry nibble bits 0 and 2; not writable by software
        dev.fault_n = (mode == ppp_mode_nibble) ? out_ff[0] : rv_empty;
        dev.perror = (mode == ppp_mode_nibble) ? out_ff[2] : 1'b0;
    end
    assign fwd_addr = addr_ff;
endmodule : ppp_port
`default_nettype wire

//--- shared/ppp_pkg.sv
// Purpose: shared constants and types for the parallel peripheral port
// Assumes: one 40 MHz clock; link pins sampled synchronously
// Notes: the ack hold count derives from a named time and the clock rate; gran_reset is a plain count
package ppp_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned clk_mhz = 40;
    localparam int unsigned periph_ack_hold_ns = 1200;
    localparam int unsigned periph_ack_hold_cyc = (periph_ack_hold_ns * clk_mhz) / 1000;
    localparam logic [15:0] gran_reset = 16'h0013;

    // ****************************************
    // fifo geometry and fields
    // ****************************************
    localparam int unsigned fifo_depth = 8;
    localparam int unsigned fifo_aw = 3;
    localparam int unsigned cmd_flag_bit = 7;
    localparam logic [6:0] addr_reset = 7'h00;
    localparam logic [7:0] byte_zero = 8'h00;

    typedef enum logic [1:0] {
        ppp_mode_compat,
        ppp_mode_nibble,
        ppp_mode_byte,
        ppp_mode_ecp
    } ppp_mode_t;

    // host-side pins seen by the device
    typedef struct packed {
        logic [7:0] data;
        logic host_clk;
        logic host_ack;
        logic reverse_req_n;
    } ppp_host_pins_t;

    // device-side pins driven toward the host
    typedef struct packed {
        logic [7:0] data;
        logic data_oe_n;
        logic periph_ack;
        logic periph_clk;
        logic ack_reverse_n;
        logic periph_req_n;
        logic fault_n;
        logic perror;
    } ppp_dev_pins_t;
endpackage : ppp_pkg

//--- logic/ppp_fifo.sv
// Purpose: small flip-flop fifo with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module ppp_fifo (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic empty
);
    import ppp_pkg::*;
    logic [7:0] mem_ff [fifo_depth];
    logic [7:0] nxt_mem [fifo_depth];
    logic [fifo_aw-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [fifo_aw:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign in_ready = (cnt_ff != fifo_aw'(0) + (fifo_aw+1)'(fifo_depth));
    assign out_valid = (cnt_ff != '0);
    assign empty = (cnt_ff == '0);
    assign out_data = mem_ff[rp_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_mem = mem_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wp_ff] = in_data;
            nxt_wp = wp_ff + fifo_aw'(1);
        end
        if (pop) begin
            nxt_rp = rp_ff + fifo_aw'(1);
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + (fifo_aw+1)'(1);
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - (fifo_aw+1)'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            for (int i = 0; i < fifo_depth; i++) begin
                mem_ff[i] <= byte_zero;
            end
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            mem_ff <= nxt_mem;
        end
    end
endmodule : ppp_fifo
`default_nettype wire

//--- tb/ppp_port_monitor.sv
// Purpose: port checker for the parallel peripheral port
// Assumes: one clock, synchronous active-low reset
// Notes: bound onto ppp_port from tb_top
`timescale 1ns/1ps
`default_nettype none
module ppp_port_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire ppp_pkg::ppp_mode_t mode,
    input wire logic dma_mode,
    input wire logic ecp_enter,
    input wire ppp_pkg::ppp_host_pins_t host,
    input wire ppp_pkg::ppp_dev_pins_t dev,
    input wire logic fwd_dat_valid,
    input wire logic fwd_cmd_valid,
    input wire logic fwd_dat_dma_req,
    input wire logic cpu_access,
    input wire logic bus_error
);
    import ppp_pkg::*;
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_bus_err_gate: assert property (bus_error == (dma_mode && cpu_access))
        else $error("bus error not tied to dma select and cpu access");
    a_idle_reset: assert property ($rose(rst_n) |->
        !dev.periph_ack && dev.periph_clk && dev.ack_reverse_n && dev.periph_req_n)
        else $error("link outputs not idle after reset");
    a_fifo_reset: assert property ($rose(rst_n) |-> !fwd_dat_valid && !fwd_cmd_valid)
        else $error("forward fifos not empty after reset");
    a_ecp_hold: assert property (ecp_enter |-> ##2 dev.periph_ack [*8])
        else $error("periph ack not held after ecp entry");
    a_ack_waits: assert property (dev.periph_ack && !host.host_clk |=> dev.periph_ack)
        else $error("periph ack dropped before host clock rose");
    a_dma_level: assert property (dma_mode && fwd_dat_valid |-> fwd_dat_dma_req)
        else $error("dma request missing while data waits");
    a_compat_fwd: assert property (mode == ppp_mode_compat |-> dev.data_oe_n)
        else $error("data driven in forward-only mode");
    a_rev_grant: assert property ($fell(dev.ack_reverse_n) |-> !$past(host.reverse_req_n))
        else $error("ack reverse without host request");
    a_ecp_strobe: assert property (mode == ppp_mode_ecp && $fell(dev.periph_clk)
        |-> !dev.ack_reverse_n)
        else $error("reverse strobe before direction grant");
    c_dma: cover property (fwd_dat_dma_req);
    c_grant: cover property ($fell(dev.ack_reverse_n));
    c_hold: cover property (ecp_enter ##2 dev.periph_ack);
endmodule : ppp_port_monitor
`default_nettype wire

//--- tb/ppp_host_model.sv
// Purpose: host-side parallel port model driving the link pins
// Assumes: signals change just after a rising edge
// Notes: data lines released by both host and device show the inverse of the last host value
`timescale 1ns/1ps
`default_nettype none
module ppp_host_model (
    input wire logic clock,
    input wire ppp_pkg::ppp_dev_pins_t dev,
    output var ppp_pkg::ppp_host_pins_t host
);
    import ppp_pkg::*;
    ppp_host_pins_t hp;
    logic hdrv;
    initial begin
        hp = '{data: 8'h00, host_clk: 1'b1, host_ack: 1'b1, reverse_req_n: 1'b1};
        hdrv = 1'b1;
    end
    // wire level from both enables, so an undriven bus never reads as a stale value
    always_comb begin
        host = hp;
        if (!hdrv) host.data = !dev.data_oe_n ? dev.data : ~hp.data;
    end
    task automatic wait_dev(input int sel, input logic lvl, output bit ok);
        logic v;
        ok = 1'b0;
        for (int i = 0; i < 400 && !ok; i++) begin
            @(posedge clock);
            v = (sel == 0) ? dev.periph_ack : (sel == 1) ? dev.periph_clk : dev.ack_reverse_n;
            ok = (v === lvl);
        end
    endtask : wait_dev
    // forward byte; ha low marks a command
    task automatic send(input logic [7:0] b, input logic ha, output bit ok);
        @(posedge clock);
        hp.data <= b;
        hp.host_ack <= ha;
        @(posedge clock);
        hp.host_clk <= 1'b0;
        wait_dev(0, 1'b1, ok);
        if (ok) hp.host_clk <= 1'b1;
        if (ok) wait_dev(0, 1'b0, ok);
        hp.data <= ~b;
    endtask : send
    // reverse byte; the host always asks for the direction, ecp waits for the grant
    task automatic rev_get(input bit req, output logic [7:0] b, output logic [1:0] sts,
        output bit ok);
        @(posedge clock);
        hdrv <= 1'b0;
        hp.host_ack <= 1'b0;
        hp.reverse_req_n <= 1'b0;
        ok = 1'b1;
        if (req) wait_dev(2, 1'b0, ok);
        if (ok) wait_dev(1, 1'b0, ok);
        b = host.data;
        sts = {dev.perror, dev.fault_n};
        hp.host_ack <= 1'b1;
        if (ok) wait_dev(1, 1'b1, ok);
        hp.host_ack <= 1'b0;
        hp.reverse_req_n <= 1'b1;
        hdrv <= 1'b1;
    endtask : rev_get
endmodule : ppp_host_model
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for the parallel peripheral port
// Assumes: host model on the link, bench on the fifo side
// Notes: divider shortened to a tick every four clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ppp_pkg::*;
    logic clock, rst_n, dma_mode, cmd_store_dis, ecp_enter, cpu_access, bus_error;
    ppp_mode_t mode;
    ppp_host_pins_t host;
    ppp_dev_pins_t dev;
    logic [6:0] fwd_addr;
    logic fwd_dat_valid, fwd_dat_ready, fwd_cmd_valid, fwd_cmd_ready, rev_valid, rev_ready;
    logic [7:0] fwd_dat_data, fwd_cmd_data, rev_data, rb;
    logic fwd_dat_dma_req, fwd_cmd_dma_req, rev_dma_req;
    int err_total = 0;
    int checked = 0;
    ppp_port ppp_port_inst (.clock(clock), .rst_n(rst_n), .mode(mode), .gran_div(16'h0003),
        .dma_mode(dma_mode), .cmd_store_dis(cmd_store_dis), .ecp_enter(ecp_enter),
        .host(host), .dev(dev), .fwd_addr(fwd_addr), .fwd_dat_valid(fwd_dat_valid),
        .fwd_dat_ready(fwd_dat_ready), .fwd_dat_data(fwd_dat_data),
        .fwd_cmd_valid(fwd_cmd_valid), .fwd_cmd_ready(fwd_cmd_ready),
        .fwd_cmd_data(fwd_cmd_data), .rev_valid(rev_valid), .rev_ready(rev_ready),
        .rev_data(rev_data), .fwd_dat_dma_req(fwd_dat_dma_req),
        .fwd_cmd_dma_req(fwd_cmd_dma_req), .rev_dma_req(rev_dma_req),
        .cpu_access(cpu_access), .bus_error(bus_error));
    ppp_host_model ppp_host_model_inst (.clock(clock), .dev(dev), .host(host));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic miss(input string m);
        $display("MISMATCH %0t %s", $time, m);
        err_total++;
    endtask : miss
    function automatic bit cnt(input bit bad);
        checked++;
        return bad;
    endfunction : cnt
    task automatic hang(input string m);
        miss(m);
        conclude();
    endtask : hang
    task automatic hs(input logic [7:0] b, input logic ha);
        bit ok;
        ppp_host_model_inst.send(b, ha, ok);
        if (!ok) hang("forward handshake stalled");
    endtask : hs
    task automatic pop(input logic [7:0] exp, input bit cmd);
        int i;
        for (i = 0; i < 400 && (cmd ? fwd_cmd_valid : fwd_dat_valid) !== 1'b1; i++)
            @(negedge clock);
        if (i == 400) hang("fifo never valid");
        if (cnt((cmd ? fwd_cmd_data : fwd_dat_data) !== exp)) miss("fifo data wrong");
        @(posedge clock);
        if (cmd) fwd_cmd_ready <= 1'b1; else fwd_dat_ready <= 1'b1;
        @(posedge clock);
        fwd_cmd_ready <= 1'b0;
        fwd_dat_ready <= 1'b0;
    endtask : pop
    task automatic push(input logic [7:0] b);
        int i;
        @(posedge clock);
        rev_valid <= 1'b1;
        rev_data <= b;
        for (i = 0; i < 400; i++) begin
            @(posedge clock);
            if (rev_ready === 1'b1) break;
        end
        rev_valid <= 1'b0;
        if (i == 400) hang("reverse fifo refused");
    endtask : push
    task automatic settle_empty(input string m);
        repeat (8) @(negedge clock);
        if (cnt(fwd_dat_valid !== 1'b0 || fwd_cmd_valid !== 1'b0)) miss(m);
    endtask : settle_empty
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_bus_err();
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {dma_mode, cpu_access} <= 2'(i);
            @(negedge clock);
            if (cnt(bus_error !== (i == 3))) miss("bus error level");
        end
        @(posedge clock);
        {dma_mode, cpu_access} <= 2'h2;
    endtask : t_bus_err
    task automatic t_compat();
        hs(8'h96, 1'b1);
        repeat (2) @(negedge clock);
        if (cnt(fwd_dat_dma_req !== 1'b1)) miss("no dma request");
        pop(8'h96, 1'b0);
        repeat (2) @(negedge clock);
        if (cnt(fwd_dat_dma_req !== 1'b0)) miss("dma request after empty");
    endtask : t_compat
    task automatic t_ecp_hold();
        int c;
        c = 0;
        @(posedge clock);
        mode <= ppp_mode_ecp;
        ecp_enter <= 1'b1;
        @(posedge clock);
        ecp_enter <= 1'b0;
        repeat (150) @(negedge clock) if (dev.periph_ack === 1'b1) c++;
        if (cnt(c < periph_ack_hold_cyc - 2 || c > periph_ack_hold_cyc + 2)) miss("hold");
    endtask : t_ecp_hold
    task automatic t_ecp_fwd();
        hs(8'h5a, 1'b1);
        pop(8'h5a, 1'b0);
        // count nine writes ten copies, overrunning the eight-deep fifo, so the link must stall meanwhile
        hs(8'h09, 1'b0);
        fork
            hs(8'h3c, 1'b1);
        join_none
        repeat (10) pop(8'h3c, 1'b0);
        wait fork;
        settle_empty("extra rle copies");
    endtask : t_ecp_fwd
    task automatic t_addr();
        hs(8'hff, 1'b0);
        @(negedge clock);
        if (cnt(fwd_addr !== 7'h7f)) miss("channel address top");
        hs(8'h85, 1'b0);
        @(negedge clock);
        if (cnt(fwd_addr !== 7'h05)) miss("channel address low");
        settle_empty("address stored in a fifo");
    endtask : t_addr
    task automatic t_ucmd();
        hs(8'h00, 1'b0);
        hs(8'h4e, 1'b0);
        @(negedge clock);
        if (cnt(fwd_cmd_dma_req !== 1'b1)) miss("no command dma request");
        pop(8'h4e, 1'b1);
        @(posedge clock);
        cmd_store_dis <= 1'b1;
        hs(8'h00, 1'b0);
        hs(8'h4e, 1'b0);
        settle_empty("command kept while disabled");
        @(posedge clock);
        cmd_store_dis <= 1'b0;
    endtask : t_ucmd
    task automatic t_rev(input ppp_mode_t m, input logic [7:0] b);
        bit ok;
        logic [1:0] sb;
        @(posedge clock);
        mode <= m;
        push(b);
        repeat (2) @(negedge clock);
        if (cnt(m == ppp_mode_ecp && dev.periph_req_n !== 1'b0)) miss("no request");
        if (cnt(rev_dma_req !== 1'b1)) miss("no reverse dma request");
        if (cnt(dev.fault_n !== 1'b0)) miss("fault line not showing waiting data");
        ppp_host_model_inst.rev_get(m == ppp_mode_ecp, rb, sb, ok);
        if (!ok) hang("reverse handshake stalled");
        if (cnt(rb !== b)) miss("reverse byte wrong");
    endtask : t_rev
    // status bits 2 and 0 of each half show on perror and fault
    task automatic t_nib();
        bit ok;
        logic [1:0] s0, s1;
        @(posedge clock);
        mode <= ppp_mode_nibble;
        push(8'h65);
        ppp_host_model_inst.rev_get(1'b0, rb, s0, ok);
        if (ok) ppp_host_model_inst.rev_get(1'b0, rb, s1, ok);
        if (!ok) hang("nibble handshake stalled");
        if (cnt(s0 !== 2'b11 || s1 !== 2'b10)) miss("nibble halves wrong");
    endtask : t_nib
    initial begin
        rst_n = 1'b0;
        mode = ppp_mode_compat;
        {dma_mode, cmd_store_dis, ecp_enter, cpu_access} = 4'h0;
        {fwd_dat_ready, fwd_cmd_ready, rev_valid} = 3'h0;
        rev_data = 8'h00;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_bus_err();
        t_compat();
        t_ecp_hold();
        t_ecp_fwd();
        t_addr();
        t_ucmd();
        t_rev(ppp_mode_ecp, 8'ha7);
        t_rev(ppp_mode_byte, 8'h3e);
        t_nib();
        conclude();
    end
endmodule : tb_top
bind ppp_port ppp_port_monitor ppp_port_monitor_inst (.clock(clock), .rst_n(rst_n),
    .mode(mode), .dma_mode(dma_mode), .ecp_enter(ecp_enter), .host(host), .dev(dev),
    .fwd_dat_valid(fwd_dat_valid), .fwd_cmd_valid(fwd_cmd_valid),
    .fwd_dat_dma_req(fwd_dat_dma_req), .cpu_access(cpu_access), .bus_error(bus_error));
`default_nettype wire
